// ==== hdl/dasc_pkg.sv ====
// Constants and types shared by the ADC scan DMA control block
package dasc_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 14;
    localparam int unsigned INDEX_W  = 12;

    // Register indices; byte address is four times the index
    localparam logic [INDEX_W-1:0] IDX_RESULT_BASE  = 12'hfbd;
    localparam logic [INDEX_W-1:0] IDX_SCAN_CONTROL = 12'hfbe;
    localparam logic [INDEX_W-1:0] IDX_SCAN_STATUS  = 12'hfbf;
    localparam logic [INDEX_W-1:0] IDX_EVT_STATUS   = 12'hfc0;
    localparam logic [INDEX_W-1:0] IDX_EVT_CLEAR    = 12'hfc1;
    localparam logic [INDEX_W-1:0] IDX_EVT_ENABLE   = 12'hfc2;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int unsigned CTL_EN_BIT    = 7;
    localparam int unsigned CTL_SCAN_IRQ_ENABLE_BIT = 6;
    localparam int unsigned CUR_LSB       = 4;
    localparam int unsigned FLAG_SCAN     = 2;
    localparam int unsigned FLAG_CH1      = 1;
    localparam int unsigned FLAG_CH0      = 0;
    localparam int unsigned NUM_FLAGS     = 3;

    // ------------------------------------------------------------------
    // Values after reset and limits
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [6:0] RST_BASE    = 7'h00;
    localparam logic [2:0] RST_FLAGS   = 3'h0;
    localparam logic [3:0] LAST_MAX    = 4'hb;
    localparam logic [3:0] INPUT_FIRST = 4'h0;

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SCAN_IDLE  = 4'b0001,
        SCAN_START = 4'b0010,
        SCAN_CONV  = 4'b0100,
        SCAN_XFER  = 4'b1000
    } dasc_scan_state_t;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_HIGH = 3'b010,
        WR_LOW  = 3'b100
    } dasc_wr_state_t;

endpackage : dasc_pkg

// ==== hdl/dasc_wr_if.sv ====
// Request path from the scan sequencer to the result writer
`timescale 1ns/100ps
`default_nettype none

interface dasc_wr_if;
    logic        req;
    logic [11:0] addr;
    logic [9:0]  data;
    logic        busy;
    logic        done;

    modport seq    (output req, output addr, output data,
                    input busy, input done);
    modport writer (input req, input addr, input data,
                    output busy, output done);
endinterface : dasc_wr_if

`default_nettype wire

// ==== hdl/dasc_result_writer.sv ====
// Writes one 10-bit result as two bytes into the register file
`timescale 1ns/100ps
`default_nettype none

module dasc_result_writer (
    input  wire logic   core_clk_i,
    input  wire logic   rst_b_i,
    dasc_wr_if.writer   wr,
    output logic        rf_we_o,
    output logic [11:0] rf_addr_o,
    output logic [7:0]  rf_wdata_o,
    input  wire logic   rf_ready_i
);

    dasc_pkg::dasc_wr_state_t state_q;
    logic [1:0]               low_bits_q;
    logic                     done_q;

    assign wr.busy = (state_q != dasc_pkg::WR_IDLE);
    assign wr.done = done_q;

    // RULE15 - high byte first
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_q    <= dasc_pkg::WR_IDLE;
            rf_we_o    <= 1'b0;
            rf_addr_o  <= 12'h000;
            rf_wdata_o <= 8'h00;
            low_bits_q <= 2'h0;
            done_q     <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                dasc_pkg::WR_IDLE: begin
                    if (wr.req) begin
                        rf_we_o    <= 1'b1;
                        rf_addr_o  <= {wr.addr[11:1], 1'b0};
                        rf_wdata_o <= wr.data[9:2];
                        low_bits_q <= wr.data[1:0];
                        state_q    <= dasc_pkg::WR_HIGH;
                    end
                end
                dasc_pkg::WR_HIGH: begin
                    if (rf_ready_i) begin
                        rf_addr_o  <= {rf_addr_o[11:1], 1'b1};
                        rf_wdata_o <= {low_bits_q, 6'h00};
                        state_q    <= dasc_pkg::WR_LOW;
                    end
                end
                dasc_pkg::WR_LOW: begin
                    if (rf_ready_i) begin
                        rf_we_o <= 1'b0;
                        done_q  <= 1'b1;
                        state_q <= dasc_pkg::WR_IDLE;
                    end
                end
                default: begin
                    rf_we_o <= 1'b0;
                    state_q <= dasc_pkg::WR_IDLE;
                end
            endcase
        end
    end

endmodule : dasc_result_writer

`default_nettype wire

// ==== hdl/dasc_top.sv ====
// ADC scan DMA control: APB registers, scan sequencer, interrupt logic
//
// Overview of operation
// RULE1 - Enable runs scan with transfers; clear stops it, zeroes last field.
// RULE2 - With interrupt enable, interrupt once last input's data has moved.
// RULE3 - With interrupt enable cleared, the scan raises no interrupts.
// RULE4 - Last field N converts inputs 0 to N; legal 0 to 11.
// RULE5 - Each scan starts at input 0, ascending order.
// RULE6 - Each input converts fully, then transfers, before the next input.
// RULE7 - Software writes zeros into control bits five and four.
// RULE8 - Status current input field shows the input now being converted.
// RULE9 - Any status read clears scan, channel 1 and channel 0 flags.
// RULE10 - Handler reading status must service all three flagged sources.
// RULE11 - Scan flag sets when last input transferred and interrupt raised.
// RULE12 - Channel 1 flag sets when channel 1 finishes at end address.
// RULE13 - Channel 0 flag sets when channel 0 finishes at end address.
// RULE14 - Result address is base, input number, then a zero bit.
// RULE15 - Result high byte at even address, rest at following odd.
// RULE16 - After last input the scan restarts at 0 while enabled.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module dasc_top (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [13:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // ADC converter
    output logic             adc_start_o,
    output logic [3:0]       adc_input_o,
    input  wire logic        adc_done_i,
    input  wire logic [9:0]  adc_data_i,
    // Register file write port
    output logic             rf_we_o,
    output logic [11:0]      rf_addr_o,
    output logic [7:0]       rf_wdata_o,
    input  wire logic        rf_ready_i,
    // General channel completion pulses
    input  wire logic        ch0_done_i,
    input  wire logic        ch1_done_i,
    // Interrupt
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    dasc_wr_if wr_if ();

    dasc_pkg::dasc_scan_state_t state_q;
    logic                       scan_en_q;
    logic                       irq_en_q;
    logic [3:0]                 last_q;
    logic [6:0]                 base_q;
    logic [3:0]                 cur_q;
    logic [2:0]                 flags_q;
    logic [2:0]                 flags_d;
    logic [2:0]                 evt_q;
    logic [2:0]                 evt_d;
    logic [2:0]                 evt_en_q;
    logic [2:0]                 evt_en_d;
    logic [2:0]                 seen_q;
    logic                       scan_done;
    logic [2:0]                 events;
    logic [3:0]                 last_eff;
    logic                       req_q;
    logic [9:0]                 data_q;
    logic                       setup;
    logic                       access;
    logic                       wr_acc;
    logic                       rd_acc;
    logic                       hit;
    logic [11:0]                index;
    logic [7:0]                 rd_val;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign index    = paddr_i[13:2];
    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i;
    assign wr_acc   = access & pwrite_i & ~pslverr_o;
    assign rd_acc   = access & ~pwrite_i & ~pslverr_o;
    // Zero wait state: read data is captured in the setup cycle
    assign pready_o = access;

    always_comb begin
        hit = 1'b1;
        case (index)
            dasc_pkg::IDX_RESULT_BASE:  rd_val = {base_q, 1'b0};
            dasc_pkg::IDX_SCAN_CONTROL: rd_val = {scan_en_q, irq_en_q,
                                                  2'b00, last_q};
            // RULE8 - live input number
            dasc_pkg::IDX_SCAN_STATUS:  rd_val = {cur_q, 1'b0, flags_q};
            dasc_pkg::IDX_EVT_STATUS:   rd_val = {5'h00, evt_q};
            dasc_pkg::IDX_EVT_CLEAR:    rd_val = 8'h00;
            dasc_pkg::IDX_EVT_ENABLE:   rd_val = {5'h00, evt_en_q};
            default: begin
                rd_val = 8'h00;
                hit    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
            seen_q    <= 3'h0;
        end else if (setup) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_val};
            pslverr_o <= ~hit;
            // Only flags the reader actually saw may be cleared
            seen_q    <= (!pwrite_i && index == dasc_pkg::IDX_SCAN_STATUS)
                         ? flags_q : 3'h0;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            scan_en_q <= dasc_pkg::RST_CONTROL[dasc_pkg::CTL_EN_BIT];
            irq_en_q  <= dasc_pkg::RST_CONTROL[dasc_pkg::CTL_SCAN_IRQ_ENABLE_BIT];
            last_q    <= dasc_pkg::RST_CONTROL[3:0];
        end else if (wr_acc && index == dasc_pkg::IDX_SCAN_CONTROL) begin
            scan_en_q <= pwdata_i[dasc_pkg::CTL_EN_BIT];
            irq_en_q  <= pwdata_i[dasc_pkg::CTL_SCAN_IRQ_ENABLE_BIT];
            // RULE1 - disable zeroes last
            last_q    <= pwdata_i[dasc_pkg::CTL_EN_BIT] ? pwdata_i[3:0]
                                                        : 4'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            base_q   <= dasc_pkg::RST_BASE;
            evt_en_q <= dasc_pkg::RST_FLAGS;
        end else if (wr_acc) begin
            if (index == dasc_pkg::IDX_RESULT_BASE) begin
                base_q <= pwdata_i[7:1];
            end
            if (index == dasc_pkg::IDX_EVT_ENABLE) begin
                evt_en_q <= pwdata_i[2:0];
            end
        end
    end

    // Stored unclamped, so with enable set software reads back what it wrote
    // RULE4 - out of range clamps to 11
    assign last_eff = (last_q > dasc_pkg::LAST_MAX) ? dasc_pkg::LAST_MAX
                                                    : last_q;

    // ------------------------------------------------------------------
    // Scan sequencer
    // ------------------------------------------------------------------
    assign wr_if.req  = req_q;
    // RULE14 - base, input, zero
    assign wr_if.addr = {base_q, cur_q, 1'b0};
    assign wr_if.data = data_q;

    assign adc_input_o = cur_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            state_q     <= dasc_pkg::SCAN_IDLE;
            cur_q       <= dasc_pkg::INPUT_FIRST;
            adc_start_o <= 1'b0;
            req_q       <= 1'b0;
            data_q      <= 10'h000;
            scan_done   <= 1'b0;
        end else begin
            adc_start_o <= 1'b0;
            req_q       <= 1'b0;
            scan_done   <= 1'b0;
            if (!scan_en_q) begin
                // RULE1 - stop and rewind
                state_q <= dasc_pkg::SCAN_IDLE;
                cur_q   <= dasc_pkg::INPUT_FIRST;
            end else begin
                case (state_q)
                    dasc_pkg::SCAN_IDLE: begin
                        // RULE5 - begin at input 0
                        cur_q   <= dasc_pkg::INPUT_FIRST;
                        state_q <= dasc_pkg::SCAN_START;
                    end
                    dasc_pkg::SCAN_START: begin
                        // Wait until an aborted transfer has drained
                        if (!wr_if.busy) begin
                            adc_start_o <= 1'b1;
                            state_q     <= dasc_pkg::SCAN_CONV;
                        end
                    end
                    dasc_pkg::SCAN_CONV: begin
                        // RULE6 - transfer after conversion
                        if (adc_done_i) begin
                            data_q  <= adc_data_i;
                            req_q   <= 1'b1;
                            state_q <= dasc_pkg::SCAN_XFER;
                        end
                    end
                    dasc_pkg::SCAN_XFER: begin
                        if (wr_if.done) begin
                            state_q <= dasc_pkg::SCAN_START;
                            if (cur_q >= last_eff) begin
                                // RULE16 - wrap to input 0
                                cur_q     <= dasc_pkg::INPUT_FIRST;
                                scan_done <= 1'b1;
                            end else begin
                                // RULE5 - ascending order
                                cur_q <= cur_q + 4'h1;
                            end
                        end
                    end
                    default: begin
                        state_q <= dasc_pkg::SCAN_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------------
    // RULE3 - no scan event when disabled
    // RULE2 - scan event after last transfer
    assign events[dasc_pkg::FLAG_SCAN] = scan_done & irq_en_q;
    // RULE12 - channel 1 completion
    assign events[dasc_pkg::FLAG_CH1]  = ch1_done_i;
    // RULE13 - channel 0 completion
    assign events[dasc_pkg::FLAG_CH0]  = ch0_done_i;

    always_comb begin
        flags_d = flags_q;
        evt_d   = evt_q;
        // RULE9 - read clears flags
        if (rd_acc && index == dasc_pkg::IDX_SCAN_STATUS) begin
            flags_d = flags_q & ~seen_q;
        end
        if (wr_acc && index == dasc_pkg::IDX_EVT_CLEAR) begin
            evt_d = evt_q & ~pwdata_i[2:0];
        end
        // RULE11 - set wins over clear
        flags_d = flags_d | events;
        evt_d   = evt_d | events;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            flags_q <= dasc_pkg::RST_FLAGS;
            evt_q   <= dasc_pkg::RST_FLAGS;
        end else begin
            flags_q <= flags_d;
            evt_q   <= evt_d;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------------
    // Enable written this cycle counts at once, so the level never lags
    always_comb begin
        evt_en_d = evt_en_q;
        if (wr_acc && index == dasc_pkg::IDX_EVT_ENABLE) begin
            evt_en_d = pwdata_i[2:0];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(evt_d & evt_en_d);
        end
    end

    // ------------------------------------------------------------------
    // Result writer
    // ------------------------------------------------------------------
    // Byte pair is atomic: an abort lets it finish
    dasc_result_writer u_writer (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .wr         (wr_if.writer),
        .rf_we_o    (rf_we_o),
        .rf_addr_o  (rf_addr_o),
        .rf_wdata_o (rf_wdata_o),
        .rf_ready_i (rf_ready_i)
    );

endmodule : dasc_top

`default_nettype wire

// ==== testbench/dasc_top_properties.sv ====
// Port-level checks for the ADC scan DMA control block
`timescale 1ns/100ps
`default_nettype none

module dasc_top_properties (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic        adc_start_o,
    input wire logic [3:0]  adc_input_o,
    input wire logic        rf_we_o,
    input wire logic [11:0] rf_addr_o,
    input wire logic [7:0]  rf_wdata_o,
    input wire logic        rf_ready_i
);
    logic [3:0] prev_in_q;

    // Input of the previous conversion start
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) prev_in_q <= 4'h0;
        else if (adc_start_o) prev_in_q <= adc_input_o;
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_input_step: assert property (
        adc_start_o && adc_input_o != 4'h0 |-> adc_input_o == prev_in_q + 4'h1)
        else $error("conversion inputs not ascending");
    chk_input_range: assert property (
        adc_start_o |-> adc_input_o <= 4'hb)
        else $error("conversion input above eleven");
    chk_start_pulse: assert property (
        adc_start_o |=> !adc_start_o [*2])
        else $error("start pulse too long");
    chk_xfer_no_start: assert property (
        rf_we_o |-> !adc_start_o)
        else $error("conversion started during transfer");
    chk_we_hold: assert property (
        rf_we_o && !rf_ready_i |=>
        rf_we_o && $stable(rf_addr_o) && $stable(rf_wdata_o))
        else $error("write request changed before accept");
    chk_first_even: assert property (
        $rose(rf_we_o) |-> !rf_addr_o[0])
        else $error("byte pair not started at even address");
    chk_pair_odd: assert property (
        rf_we_o && rf_ready_i && !rf_addr_o[0] |=> rf_we_o && rf_addr_o[0]
        && rf_addr_o[11:1] == $past(rf_addr_o[11:1]))
        else $error("odd byte missing after even byte");
    chk_odd_low: assert property (
        rf_we_o && rf_addr_o[0] |-> rf_wdata_o[5:0] == 6'h00)
        else $error("low byte padding not zero");
endmodule : dasc_top_properties

bind dasc_top dasc_top_properties u_props (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .adc_start_o(adc_start_o),
    .adc_input_o(adc_input_o),
    .rf_we_o    (rf_we_o),
    .rf_addr_o  (rf_addr_o),
    .rf_wdata_o (rf_wdata_o),
    .rf_ready_i (rf_ready_i)
);

`default_nettype wire

// ==== testbench/dasc_adc_rf_model.sv ====
// Converter and register file write port seen by the scan block
`timescale 1ns/100ps
`default_nettype none

module dasc_adc_rf_model (
    input  wire logic       core_clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       adc_start_i,
    input  wire logic [3:0] adc_input_i,
    input  wire logic       hold_i,
    output logic            adc_done_o,
    output logic [9:0]      adc_data_o,
    output logic            rf_ready_o
);
    logic [3:0] in_q;
    logic [2:0] cnt_q;
    logic       busy_q;

    // Data is only valid with done; otherwise it keeps changing
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            busy_q     <= 1'b0;
            cnt_q      <= 3'h0;
            in_q       <= 4'h0;
            adc_done_o <= 1'b0;
            adc_data_o <= 10'h000;
        end else begin
            adc_done_o <= 1'b0;
            adc_data_o <= ~adc_data_o;
            if (adc_start_i) begin
                busy_q <= 1'b1;
                cnt_q  <= 3'h0;
                in_q   <= adc_input_i;
            end else if (busy_q && cnt_q != 3'h5) begin
                cnt_q <= cnt_q + 3'h1;
            end else if (busy_q && !hold_i) begin
                busy_q     <= 1'b0;
                adc_done_o <= 1'b1;
                adc_data_o <= {in_q, 6'h2b};
            end
        end
    end

    // Register file stalls every other cycle
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) rf_ready_o <= 1'b0;
        else rf_ready_o <= ~rf_ready_o;
    end
endmodule : dasc_adc_rf_model

`default_nettype wire

// ==== testbench/dasc_adc_scan_control_tb.sv ====
// Register-level tests of the ADC scan DMA control block
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    err_total++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module dma_adc_scan_control_tb;
    logic        core_clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [13:0] paddr_i = 14'h0000;
    logic [31:0] pwdata_i = 32'h0;
    logic        hold = 1'b0;
    logic        ch0_done_i = 1'b0;
    logic        ch1_done_i = 1'b0;
    logic [31:0] prdata_o, rd;
    logic        pready_o, pslverr_o, err_s, irq_o;
    logic        adc_start_o, adc_done_i, rf_we_o, rf_ready_i;
    logic [3:0]  adc_input_o;
    logic [9:0]  adc_data_i;
    logic [11:0] rf_addr_o;
    logic [7:0]  rf_wdata_o;
    logic [19:0] wq[$];
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;

    dasc_top u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .adc_start_o(adc_start_o), .adc_input_o(adc_input_o),
        .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
        .rf_we_o(rf_we_o), .rf_addr_o(rf_addr_o), .rf_wdata_o(rf_wdata_o),
        .rf_ready_i(rf_ready_i), .ch0_done_i(ch0_done_i),
        .ch1_done_i(ch1_done_i), .irq_o(irq_o));

    dasc_adc_rf_model u_model (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .adc_start_i(adc_start_o), .adc_input_i(adc_input_o),
        .hold_i(hold), .adc_done_o(adc_done_i), .adc_data_o(adc_data_i),
        .rf_ready_o(rf_ready_i));

    initial begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    // Accepted register file bytes, address and data
    always @(posedge core_clk_i) begin
        if (rf_we_o === 1'b1 && rf_ready_i === 1'b1)
            wq.push_back({rf_addr_o, rf_wdata_o});
    end

    // Hang guard: under a thousand cycles expected
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    // -----------------------------------------------------------------
    // Bus and test tasks
    // -----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] idx,
                       input logic [7:0] wd);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= {idx, 2'b00};
        pwdata_i  <= {24'h0, wd};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err_s = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask : apb

    task automatic scan_check(input logic [3:0] last, input logic ie);
        logic [9:0] d;
        int         n;
        wq.delete();
        apb(1'b1, dasc_pkg::IDX_SCAN_CONTROL, {1'b1, ie, 2'h0, last});
        if (last != 4'h0) begin
            while (wq.size() < 2) @(posedge core_clk_i);
            hold <= 1'b1;
            repeat (12) @(posedge core_clk_i);
            apb(1'b0, dasc_pkg::IDX_SCAN_STATUS, 8'h00);
            `CHK(rd[7:4], 4'h1)
            hold <= 1'b0;
        end
        while (wq.size() < 2 * last + 4) @(posedge core_clk_i);
        for (int i = 0; i <= last; i++) begin
            d = {i[3:0], 6'h2b};
            `CHK(wq[2*i], {7'h72, i[3:0], 1'b0, d[9:2]})
            `CHK(wq[2*i+1], {7'h72, i[3:0], 1'b1, d[1:0], 6'h00})
        end
        `CHK(wq[2*last+2][19:8], 12'he40)
        `CHK(irq_o, ie)
        apb(1'b1, dasc_pkg::IDX_SCAN_CONTROL, 8'h00);
        apb(1'b0, dasc_pkg::IDX_SCAN_STATUS, 8'h00);
        `CHK(rd, {29'h0, ie, 2'b00})
        apb(1'b0, dasc_pkg::IDX_SCAN_STATUS, 8'h00);
        `CHK(rd, 32'h0)
        apb(1'b1, dasc_pkg::IDX_EVT_CLEAR, 8'h07);
        repeat (20) @(posedge core_clk_i);
        n = wq.size();
        repeat (40) @(posedge core_clk_i);
        `CHK(wq.size(), n)
        `CHK(irq_o, 1'b0)
        $display("scan up to input %0d finished", last);
    endtask : scan_check

    task automatic pulse(input logic ch1);
        if (ch1) ch1_done_i <= 1'b1;
        else ch0_done_i <= 1'b1;
        @(posedge core_clk_i);
        ch0_done_i <= 1'b0;
        ch1_done_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
    endtask : pulse

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        @(posedge core_clk_i);
        apb(1'b0, dasc_pkg::IDX_SCAN_CONTROL, 8'h00);
        `CHK(rd[7:0], dasc_pkg::RST_CONTROL)
        apb(1'b0, dasc_pkg::IDX_SCAN_STATUS, 8'h00);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h000, 8'h00);
        `CHK({err_s, rd}, {1'b1, 32'h0})
        apb(1'b1, dasc_pkg::IDX_RESULT_BASE, 8'he4);
        apb(1'b0, dasc_pkg::IDX_RESULT_BASE, 8'h00);
        `CHK(rd, 32'he4)
        apb(1'b1, dasc_pkg::IDX_SCAN_CONTROL, 8'h45);
        apb(1'b0, dasc_pkg::IDX_SCAN_CONTROL, 8'h00);
        `CHK(rd, 32'h40)
        apb(1'b1, dasc_pkg::IDX_EVT_ENABLE, 8'h07);
        scan_check(4'h2, 1'b1);
        scan_check(4'hb, 1'b0);
        scan_check(4'h0, 1'b1);
        wq.delete();
        apb(1'b1, dasc_pkg::IDX_SCAN_CONTROL, 8'h8f);
        apb(1'b0, dasc_pkg::IDX_SCAN_CONTROL, 8'h00);
        `CHK(rd[3:0], 4'hf)
        while (wq.size() < 26) @(posedge core_clk_i);
        `CHK(wq[24][19:8], 12'he40)
        apb(1'b1, dasc_pkg::IDX_SCAN_CONTROL, 8'h00);
        repeat (20) @(posedge core_clk_i);
        $display("clamped scan finished");
        pulse(1'b0);
        `CHK(irq_o, 1'b1)
        apb(1'b0, dasc_pkg::IDX_EVT_STATUS, 8'h00);
        `CHK(rd, 32'h1)
        apb(1'b0, dasc_pkg::IDX_SCAN_STATUS, 8'h00);
        `CHK(rd, 32'h1)
        apb(1'b1, dasc_pkg::IDX_EVT_CLEAR, 8'h01);
        @(posedge core_clk_i);
        `CHK(irq_o, 1'b0)
        apb(1'b1, dasc_pkg::IDX_EVT_ENABLE, 8'h00);
        pulse(1'b1);
        `CHK(irq_o, 1'b0)
        apb(1'b0, dasc_pkg::IDX_SCAN_STATUS, 8'h00);
        `CHK(rd, 32'h2)
        $display("channel events finished");
        complete_run();
    end
endmodule : dma_adc_scan_control_tb

`default_nettype wire
